// ### verilog/etu_core.sv
/*
  emulation trigger unit: memory and register triggers, complex
  triggers, four-state sequencer, trace capture, execution and
  peripheral clock control, avalon-mm register slave.
  assumes cpu bus observation inputs are on clk; the debug port
  bridge outside drives the avalon master.
*/
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "etu_cfg.svh"
module etu_core
  import etu_pkg::*;
(
  input wire logic clk, // system clock, 200 mhz
  input wire logic rst, // synchronous reset, high
  input wire logic [7:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // write lanes
  output logic [31:0] avs_readdata, // read data, registered
  output logic avs_waitrequest, // stall of a read
  input wire etu_bus_t bus, // observed memory bus cycle
  input wire etu_regwr_t regwr, // observed register write
  input wire logic instr_done, // cpu finished one instruction
  input wire logic [`ETU_AW-1:0] next_pc, // address after current instr
  output logic cpu_halt, // emulation stop, registered
  output logic [`ETU_PM_N-1:0] periph_clk_en // module clock enables
);
  // ****************************************
  // register storage and bus decode
  // ****************************************
  logic [31:0] cfg_q [0:`ETU_W_CLKC]; // software config words
  logic [5:0] widx; // word index
  logic [4:0] cmd; // execution command pulses
  logic tclr; // trace clear pulse
  logic [2:0] tidx_q; // trace read pointer
  logic [1:0] rd_cnt_q; // read latency counter
  logic [31:0] rd_mux; // read data selection
  etu_trace_t tr_rd; // trace ram read data
  assign widx = avs_address[7:2];

  // command word is write-only, seen only as pulses
  assign cmd = (avs_write && widx == `ETU_W_EXEC) ? avs_writedata[4:0] : 5'h00;
  assign tclr = avs_write && widx == `ETU_W_TIDX && avs_writedata[`ETU_TI_CLR];

  // config write, all words reset to zero so no complex trigger fires
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int w = 0; w <= `ETU_W_CLKC; w++) cfg_q[w] <= `ETU_ZERO;
    end else if (avs_write && widx <= `ETU_W_CLKC) begin
      cfg_q[widx] <= etu_be_merge(cfg_q[widx], avs_writedata, avs_byteenable);
    end
  end

  // trace read pointer
  always_ff @(posedge clk) begin
    if (rst) tidx_q <= 3'h0;
    else if (avs_write && widx == `ETU_W_TIDX) tidx_q <= avs_writedata[2:0];
  end

  // reads wait two cycles so trace ram data is current
  always_ff @(posedge clk) begin
    if (rst) rd_cnt_q <= 2'h0;
    else if (avs_read && rd_cnt_q != `ETU_RD_LAT) rd_cnt_q <= rd_cnt_q + 2'h1;
    else rd_cnt_q <= 2'h0;
  end
  // writes never wait
  assign avs_waitrequest = avs_read && rd_cnt_q != `ETU_RD_LAT;

  // ****************************************
  // triggers
  // ****************************************
  logic [`ETU_MT_N-1:0] mt_hit; // memory trigger outputs
  logic [`ETU_RT_N-1:0] rt_hit; // register trigger outputs
  logic [`ETU_TRIG_N-1:0] trig; // all simple triggers
  logic [`ETU_CB_N-1:0] cmb_fire; // complex trigger outputs

  // one memory trigger: bus select, mask, relation, access filter
  function automatic logic mem_match(logic [31:0] ctl, logic [31:0] rv,
                                     logic [31:0] msk, etu_bus_t b);
    logic [`ETU_AW-1:0] val;
    logic [3:0] acc;
    val = ctl[`ETU_MT_BUS] ? `ETU_AW'(b.memory_data_bus) : b.memory_address_bus;
    acc = {b.fetch, b.dma, b.wr, b.rd} & ctl[`ETU_MT_COND +: 4];
    return (|acc) && etu_cmp_fn(etu_cmp_t'(ctl[`ETU_MT_CMP +: 2]),
                                val & msk[`ETU_AW-1:0],
                                rv[`ETU_AW-1:0] & msk[`ETU_AW-1:0]);
  endfunction

  // one register trigger: register select, mask, relation
  function automatic logic reg_match(logic [31:0] ctl, logic [31:0] rv,
                                     logic [31:0] msk, etu_regwr_t w);
    logic [`ETU_DW-1:0] m;
    m = msk[`ETU_DW-1:0];
    return w.en && w.idx == ctl[`ETU_RT_SEL +: 4] &&
           etu_cmp_fn(etu_cmp_t'(ctl[`ETU_RT_CMP +: 2]),
                      `ETU_AW'(w.data & m), `ETU_AW'(rv[`ETU_DW-1:0] & m));
  endfunction

  // memory triggers, one per slot
  always_comb begin
    for (int i = 0; i < `ETU_MT_N; i++) begin
      mt_hit[i] = mem_match(cfg_q[`ETU_W_MT_CTL + i], cfg_q[`ETU_W_MT_REF + i],
                            cfg_q[`ETU_W_MT_MSK + i], bus);
    end
  end

  // register write triggers
  always_comb begin
    for (int j = 0; j < `ETU_RT_N; j++) begin
      rt_hit[j] = reg_match(cfg_q[`ETU_W_RT_CTL + j], cfg_q[`ETU_W_RT_REF + j],
                            cfg_q[`ETU_W_RT_MSK + j], regwr);
    end
  end
  assign trig = {rt_hit, mt_hit};

  // complex triggers: and of the selected simple ones,
  // an empty selection never fires
  always_comb begin
    for (int k = 0; k < `ETU_CB_N; k++) begin
      cmb_fire[k] = (|cfg_q[`ETU_W_CMB + k][`ETU_TRIG_N-1:0]) &&
        ((trig & cfg_q[`ETU_W_CMB + k][`ETU_TRIG_N-1:0]) ==
         cfg_q[`ETU_W_CMB + k][`ETU_TRIG_N-1:0]);
    end
  end

  // ****************************************
  // trigger sequencer
  // ****************************************
  etu_seq_t seq_q; // current state
  etu_seq_t seq_d; // next state
  logic [31:0] seqc; // sequencer control word
  logic [31:0] tw; // transition word of current state pair
  logic [`ETU_TS_W-1:0] ts; // transitions of current state
  logic [5:0] t0; // first transition
  logic [5:0] t1; // second transition
  logic seq_ok; // break and storage may act
  assign seqc = cfg_q[`ETU_W_SEQC];

  // reset trigger beats both transitions; first beats second
  always_comb begin
    tw = cfg_q[`ETU_W_SEQT + int'(seq_q[1])];
    ts = tw[(seq_q[0] ? `ETU_TS_W : 0) +: `ETU_TS_W];
    t0 = ts[5:0];
    t1 = ts[`ETU_TS_SEC +: 6];
    seq_d = seq_q;
    if (!seqc[`ETU_SQ_EN]) begin
      seq_d = SEQ_S0; // held at start while unused
    end else if (seqc[`ETU_SQ_REN] && cmb_fire[seqc[`ETU_SQ_RSEL +: 3]]) begin
      seq_d = SEQ_S0;
    end else if (t0[`ETU_TS_EN] && cmb_fire[t0[`ETU_TS_TRG +: 3]]) begin
      seq_d = etu_seq_t'(t0[`ETU_TS_DST +: 2]);
    end else if (t1[`ETU_TS_EN] && cmb_fire[t1[`ETU_TS_TRG +: 3]]) begin
      seq_d = etu_seq_t'(t1[`ETU_TS_DST +: 2]);
    end
  end

  // state register, four states
  always_ff @(posedge clk) begin
    if (rst) seq_q <= SEQ_S0;
    else seq_q <= seq_d;
  end

  // reactions always with the sequencer off, else only once the sequence has reached its last state
  assign seq_ok = !seqc[`ETU_SQ_EN] || seq_q == SEQ_S3;

  // ****************************************
  // reactions
  // ****************************************
  logic brk_hit; // cpu stop request
  logic sto_hit; // storage request
  assign brk_hit = seq_ok && |(cmb_fire & cfg_q[`ETU_W_REACT][`ETU_RE_BRK +: 8]);
  assign sto_hit = seq_ok && |(cmb_fire & cfg_q[`ETU_W_REACT][`ETU_RE_STO +: 8]);

  // ****************************************
  // state storage
  // ****************************************
  logic [3:0] cnt_q; // entries held
  logic tr_we; // capture strobe
  etu_trace_t tr_wd; // captured entry
  // capture stops when full, entries are never overwritten
  assign tr_we = sto_hit && cnt_q < `ETU_TR_N;
  assign tr_wd = '{ctl: {bus.fetch, bus.wr, bus.rd}, memory_address_bus: bus.memory_address_bus, memory_data_bus: bus.memory_data_bus};

  // entry count; a clear wins over a capture in the same cycle
  always_ff @(posedge clk) begin
    if (rst || tclr) cnt_q <= 4'h0;
    else if (tr_we) cnt_q <= cnt_q + 4'h1;
  end

  // capture only observes the bus, the cpu never waits on it
  etu_trace_ram u_trace (
    .clk(clk),
    .rst(rst),
    .we(tr_we && !tclr),
    .waddr(cnt_q[2:0]),
    .wdata(tr_wd),
    .raddr(tidx_q),
    .rdata(tr_rd)
  );

  // ****************************************
  // execution control
  // ****************************************
  etu_exec_t exec_q; // execution state
  etu_exec_t exec_d; // next execution state
  logic halt_q; // registered stop
  logic [`ETU_AW-1:0] over_pc_q; // step-over return point

  // a breakpoint stops the cpu in every running state
  always_comb begin
    exec_d = exec_q;
    unique case (exec_q)
      EX_RUN: begin
        if (brk_hit || cmd[`ETU_EX_HALT]) exec_d = EX_HALT;
      end
      EX_HALT: begin
        if (cmd[`ETU_EX_RUN]) exec_d = EX_RUN;
        else if (cmd[`ETU_EX_STEP] || cmd[`ETU_EX_INTO]) exec_d = EX_STEP;
        else if (cmd[`ETU_EX_OVER]) exec_d = EX_OVER;
      end
      EX_STEP: begin
        if (brk_hit || instr_done) exec_d = EX_HALT;
      end
      EX_OVER: begin
        // runs through a call until the next address is fetched
        if (brk_hit || (bus.fetch && bus.memory_address_bus == over_pc_q)) exec_d = EX_HALT;
      end
    endcase
  end

  // execution state and stop output
  always_ff @(posedge clk) begin
    if (rst) begin
      exec_q <= EX_RUN;
      halt_q <= 1'b0;
    end else begin
      exec_q <= exec_d;
      halt_q <= exec_d == EX_HALT;
    end
  end

  // return point captured at the step-over command
  always_ff @(posedge clk) begin
    if (rst) over_pc_q <= '0;
    else if (exec_q == EX_HALT && cmd[`ETU_EX_OVER]) over_pc_q <= next_pc;
  end
  assign cpu_halt = halt_q;

  // ****************************************
  // peripheral clock control
  // ****************************************
  logic [31:0] clkc; // clock control word
  logic [`ETU_PM_N-1:0] ck_q; // registered enables
  assign clkc = cfg_q[`ETU_W_CLKC];

  // follows the stop by one cycle; a glitch-free gate beats speed
  always_ff @(posedge clk) begin
    if (rst) ck_q <= '1;
    else if (!halt_q) ck_q <= '1;
    else if (clkc[`ETU_CK_GLOB]) ck_q <= {`ETU_PM_N{clkc[`ETU_CK_GRUN]}};
    else ck_q <= clkc[`ETU_CK_MOD +: `ETU_PM_N];
  end
  assign periph_clk_en = ck_q;

  // ****************************************
  // read data
  // ****************************************
  always_comb begin
    rd_mux = `ETU_ZERO;
    if (widx <= `ETU_W_CLKC) begin
      rd_mux = cfg_q[widx];
    end else if (widx == `ETU_W_STAT) begin
      rd_mux[`ETU_ST_HALT] = halt_q;
      rd_mux[`ETU_ST_SEQ +: 2] = seq_q;
      rd_mux[`ETU_ST_CNT +: 4] = cnt_q;
    end else if (widx == `ETU_W_TIDX) begin
      rd_mux[2:0] = tidx_q;
    end else if (widx == `ETU_W_TADR) begin
      rd_mux[`ETU_AW-1:0] = tr_rd.memory_address_bus;
      rd_mux[`ETU_TA_CTL +: 3] = tr_rd.ctl;
    end else if (widx == `ETU_W_TDAT) begin
      rd_mux[`ETU_DW-1:0] = tr_rd.memory_data_bus;
    end
  end

  // loaded at the edge where waitrequest falls; unmapped reads zero
  always_ff @(posedge clk) begin
    if (rst) avs_readdata <= `ETU_ZERO;
    else if (avs_read && rd_cnt_q == `ETU_RD_LAT - 2'h1) avs_readdata <= rd_mux;
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_step_cmd;
    exec_q == EX_HALT && cmd[`ETU_EX_STEP] && !cmd[`ETU_EX_RUN];
  endsequence
  sequence s_step_end;
    exec_q == EX_STEP && instr_done;
  endsequence

  // slot two is the one that software points at the data bus
  a_mem_databus: assert property (
    cfg_q[`ETU_W_MT_CTL + 2][`ETU_MT_BUS] && bus.rd &&
    cfg_q[`ETU_W_MT_CTL + 2][`ETU_MT_CMP +: 2] == 2'h0 &&
    cfg_q[`ETU_W_MT_CTL + 2][`ETU_MT_COND] && cfg_q[`ETU_W_MT_MSK + 2][`ETU_AW-1:0] == '1 &&
    `ETU_AW'(bus.memory_data_bus) == cfg_q[`ETU_W_MT_REF + 2][`ETU_AW-1:0] |-> mt_hit[2])
    else $error("data bus equal match missed");
  a_mem_cond: assert property (
    cfg_q[`ETU_W_MT_CTL][`ETU_MT_COND +: 4] == 4'h0 |-> !mt_hit[0])
    else $error("memory trigger fired without condition");
  a_reg_sel: assert property (
    regwr.idx != cfg_q[`ETU_W_RT_CTL][`ETU_RT_SEL +: 4] |-> !rt_hit[0])
    else $error("register trigger fired on other register");
  // a missing selected part must block the combination
  a_cmb_and: assert property (
    cfg_q[`ETU_W_CMB][2:1] == 2'h3 && !mt_hit[2] |-> !cmb_fire[0])
    else $error("complex trigger without all parts");
  a_brk_halt: assert property (
    exec_q == EX_RUN && brk_hit |=> cpu_halt ##1 cpu_halt)
    else $error("breakpoint did not stop cpu");
  a_seq_reset: assert property (
    seqc[`ETU_SQ_EN] && seqc[`ETU_SQ_REN] && cmb_fire[seqc[`ETU_SQ_RSEL +: 3]]
    |=> seq_q == SEQ_S0)
    else $error("reset trigger did not clear sequencer");
  a_seq_gate: assert property (
    seqc[`ETU_SQ_EN] && seq_q != SEQ_S3 |-> !brk_hit && !sto_hit)
    else $error("reaction before sequence completed");
  a_trace_inc: assert property (
    tr_we && !tclr |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("trace capture not counted");
  a_trace_max: assert property (
    cnt_q <= `ETU_TR_N)
    else $error("trace count beyond depth");
  a_clk_keep: assert property (
    halt_q && clkc[`ETU_CK_GLOB] && clkc[`ETU_CK_GRUN] ##1 halt_q |-> periph_clk_en == '1)
    else $error("global keep-running ignored");
  a_rd_wait: assert property (
    avs_read && rd_cnt_q == 2'h0 |-> avs_waitrequest ##1 avs_read |-> avs_waitrequest
    ##1 avs_read |-> !avs_waitrequest)
    else $error("read answer timing wrong");
  a_step_one: assert property (
    s_step_end |=> cpu_halt)
    else $error("single step did not stop");
  a_step_start: assert property (
    s_step_cmd |=> exec_q == EX_STEP && !cpu_halt)
    else $error("step command did not release cpu");
endmodule

// ### verilog/etu_cfg.svh
/*
  constants of the emulation trigger unit: sizes, register word
  indices, field positions and timing counts.
  assumes it is included by bare name from every etu design file.
*/
// Operation
// - memory trigger watches address or data bus
// - memory compare is equal, unequal, less-equal or greater-equal
// - mask limits which bus bits are compared
// - access condition read, write, dma or fetch
// - register trigger watches a selectable written register
// - register compare eq, ne, ge, le, masked
// - eight memory bus triggers
// - two register write triggers
// - triggers combine into eight complex triggers
// - triggers drive break, storage and sequencer
// - sequencer has four states zero to three
// - two programmable transitions per state, any target
// - reset trigger returns sequencer to state zero
// - start in zero, act only in three
// - states one and two may be skipped
// - with sequencer on, events gated by sequence
// - trace stores address, data and access type
// - trace buffer holds at most eight entries
// - halt keeps chosen peripheral clocks running
// - clock hold chosen globally or per module
// - debug host configures everything over the port
// - single step, step into and step over
`ifndef ETU_CFG_SVH
`define ETU_CFG_SVH
// ****************************************
// sizes
// ****************************************
`define ETU_AW 20
`define ETU_DW 16
`define ETU_MT_N 8
`define ETU_RT_N 2
`define ETU_TRIG_N 10
`define ETU_CB_N 8
`define ETU_TR_N 8
`define ETU_PM_N 8
// ****************************************
// register word indices (byte address = 4 * index)
// ****************************************
`define ETU_W_MT_REF 0
`define ETU_W_MT_MSK 8
`define ETU_W_MT_CTL 16
`define ETU_W_RT_REF 24
`define ETU_W_RT_MSK 26
`define ETU_W_RT_CTL 28
`define ETU_W_CMB 30
`define ETU_W_REACT 38
`define ETU_W_SEQC 39
`define ETU_W_SEQT 40
`define ETU_W_CLKC 42
`define ETU_W_EXEC 43
`define ETU_W_STAT 44
`define ETU_W_TIDX 45
`define ETU_W_TADR 46
`define ETU_W_TDAT 47
// ****************************************
// field positions
// ****************************************
`define ETU_MT_BUS 0
`define ETU_MT_CMP 1
`define ETU_MT_COND 3
`define ETU_RT_SEL 0
`define ETU_RT_CMP 4
`define ETU_RE_BRK 0
`define ETU_RE_STO 8
`define ETU_SQ_EN 0
`define ETU_SQ_REN 1
`define ETU_SQ_RSEL 2
`define ETU_TS_W 16
`define ETU_TS_EN 0
`define ETU_TS_TRG 1
`define ETU_TS_DST 4
`define ETU_TS_SEC 6
`define ETU_CK_GLOB 0
`define ETU_CK_GRUN 1
`define ETU_CK_MOD 8
`define ETU_EX_HALT 0
`define ETU_EX_RUN 1
`define ETU_EX_STEP 2
`define ETU_EX_INTO 3
`define ETU_EX_OVER 4
`define ETU_TI_CLR 8
`define ETU_TA_CTL 20
`define ETU_ST_HALT 0
`define ETU_ST_SEQ 1
`define ETU_ST_CNT 3
// ****************************************
// timing and reset values
// ****************************************
`define ETU_RD_LAT 2'h2
`define ETU_ZERO 32'h0000_0000
`endif

// ### verilog/etu_pkg.sv
/*
  types and shared functions of the emulation trigger unit.
  assumes etu_cfg.svh is reachable on the include path.
*/
`include "etu_cfg.svh"
package etu_pkg;
  // comparison relation of a trigger
  typedef enum logic [1:0] {CMP_EQ, CMP_NE, CMP_LE, CMP_GE} etu_cmp_t;
  // sequencer states
  typedef enum logic [1:0] {SEQ_S0, SEQ_S1, SEQ_S2, SEQ_S3} etu_seq_t;
  // execution control states
  typedef enum logic [1:0] {EX_RUN, EX_HALT, EX_STEP, EX_OVER} etu_exec_t;
  // one observed memory bus cycle
  typedef struct packed {
    logic [`ETU_AW-1:0] memory_address_bus;
    logic [`ETU_DW-1:0] memory_data_bus;
    logic rd;
    logic wr;
    logic dma;
    logic fetch;
  } etu_bus_t;
  // one cpu register write
  typedef struct packed {
    logic en;
    logic [3:0] idx;
    logic [`ETU_DW-1:0] data;
  } etu_regwr_t;
  // one trace entry: fetch, write, read, address, data
  typedef struct packed {
    logic [2:0] ctl;
    logic [`ETU_AW-1:0] memory_address_bus;
    logic [`ETU_DW-1:0] memory_data_bus;
  } etu_trace_t;
  // shared relation test of memory and register triggers
  function automatic logic etu_cmp_fn(etu_cmp_t op, logic [`ETU_AW-1:0] a,
                                      logic [`ETU_AW-1:0] b);
    unique case (op)
      CMP_EQ: return a == b;
      CMP_NE: return a != b;
      CMP_LE: return a <= b;
      CMP_GE: return a >= b;
    endcase
  endfunction
  // byte-enable merge of a bus write
  function automatic logic [31:0] etu_be_merge(logic [31:0] old_w, logic [31:0] new_w,
                                               logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) if (be[b]) r[b*8 +: 8] = new_w[b*8 +: 8];
    return r;
  endfunction
endpackage

// ### verilog/etu_trace_ram.sv
/*
  eight-entry trace store with a registered read port.
  assumes one writer and one reader on the same clock.
*/
`timescale 1ns/1ps
`include "etu_cfg.svh"
module etu_trace_ram
  import etu_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic we, // write strobe
  input wire logic [2:0] waddr, // write entry
  input wire etu_trace_t wdata, // captured entry
  input wire logic [2:0] raddr, // read entry
  output etu_trace_t rdata // registered read data
);
  etu_trace_t mem [0:`ETU_TR_N-1]; // entries, no reset needed
  // ****************************************
  // write port
  // ****************************************
  always_ff @(posedge clk) begin
    if (we) mem[waddr] <= wdata;
  end
  // ****************************************
  // read port, one cycle latency
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) rdata <= '0;
    else rdata <= mem[raddr];
  end
endmodule

// ### verif/etu_cpu_model.sv
/*
  cpu side model: runs a fetch program while not halted, passes
  bench bus cycles through.
  assumes clk and rst of etu_core.
*/
`timescale 1ns/1ps
`include "etu_cfg.svh"
module etu_cpu_model
  import etu_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // sync reset
  input wire logic cpu_halt, // stop from the unit
  input wire logic inj_v, // bench cycle valid
  input wire etu_bus_t inj, // bench cycle
  output etu_bus_t bus, // observed bus
  output logic instr_done, // instruction ended
  output logic [`ETU_AW-1:0] next_pc // following address
);
  // ****************
  // program state
  // ****************
  logic [1:0] ph_q; // fetch phase
  logic [`ETU_AW-1:0] pc_q; // program counter
  // one fetch every fourth cycle while running
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_q <= 2'h0;
      pc_q <= 20'h0_0100;
    end else if (!cpu_halt) begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h3) pc_q <= pc_q + 20'h0_0002;
    end
  end
  // idle bus shows a changing pattern, not the last value
  always_comb begin
    instr_done = !cpu_halt && ph_q == 2'h3;
    next_pc = pc_q + 20'h0_0002;
    bus = '{memory_address_bus: ~pc_q, memory_data_bus: {14'h0, ph_q}, default: 1'b0};
    if (instr_done) bus = '{memory_address_bus: pc_q, memory_data_bus: 16'h4303, fetch: 1'b1, default: 1'b0};
    if (inj_v) bus = inj;
  end
endmodule

// ### verif/etu_core_test.sv
/*
  self-checking bench of etu_core: avalon master tasks, bus
  injection, read results checked from a queue.
  assumes etu_cpu_model beside the unit.
*/
`timescale 1ns/1ps
`include "etu_cfg.svh"
module etu_core_test
  import etu_pkg::*;
;
  logic clk, rst, rd_r, wr_r, inj_v, halt, idone, wreq;
  logic [7:0] adr, pce, pm;
  logic [31:0] wd, rdat, x;
  logic [3:0] be;
  etu_bus_t inj, bus;
  etu_regwr_t rw;
  logic [`ETU_AW-1:0] npc, a;
  logic [15:0] d, v;
  logic [19:0] ta[8];
  logic [15:0] td[8];
  int errors, n_tests, cyc;
  logic [31:0] exp_q[$];
  int w_q[$];
  etu_core u_etu_core (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd_r),
    .avs_write(wr_r), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .bus(bus), .regwr(rw), .instr_done(idone),
    .next_pc(npc), .cpu_halt(halt), .periph_clk_en(pce));
  etu_cpu_model u_etu_cpu_model (.clk(clk), .rst(rst), .cpu_halt(halt),
    .inj_v(inj_v), .inj(inj), .bus(bus), .instr_done(idone), .next_pc(npc));
  // ****************
  // helpers
  // ****************
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard, runs take about 300 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  // read data taken at the edge where waitrequest is low
  always @(posedge clk) begin
    if (rd_r && !wreq) chk($sformatf("word %0d", w_q.pop_front()), exp_q.pop_front(), rdat);
  end
  task automatic wrb(input int w, input logic [31:0] dt, input logic [3:0] b);
    @(posedge clk);
    adr <= 8'(w * 4);
    wd <= dt;
    be <= b;
    wr_r <= 1;
    do @(posedge clk); while (wreq);
    wr_r <= 0;
  endtask
  task automatic wr(input int w, input logic [31:0] dt);
    wrb(w, dt, 4'hf);
  endtask
  task automatic rd(input int w, input logic [31:0] e);
    w_q.push_back(w);
    exp_q.push_back(e);
    @(posedge clk);
    adr <= 8'(w * 4);
    rd_r <= 1;
    do @(posedge clk); while (wreq);
    rd_r <= 0;
  endtask
  // one read cycle on the observed bus
  task automatic ij(input logic [19:0] ad, input logic [15:0] dt);
    @(posedge clk);
    inj_v <= 1;
    inj <= '{memory_address_bus: ad, memory_data_bus: dt, rd: 1'b1, default: 1'b0};
    @(posedge clk);
    inj_v <= 0;
  endtask
  task automatic rwt(input logic [3:0] i, input logic [15:0] dt);
    @(posedge clk);
    rw <= '{en: 1'b1, idx: i, data: dt};
    @(posedge clk);
    rw.en <= 1'b0;
  endtask
  task automatic wt(input logic h);
    for (int i = 0; i < 200 && halt !== h; i++) @(negedge clk);
    chk("cpu_halt", 32'(h), 32'(halt));
  endtask
  task automatic ck(input logic [7:0] e);
    @(posedge clk);
    @(negedge clk);
    chk("periph_clk_en", 32'(e), 32'(pce));
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    {rst, rd_r, wr_r, inj_v, adr, wd, be, inj, rw} = '0;
    rst = 1;
    void'($urandom(88037));
    repeat (16) @(posedge clk);
    rst <= 0;
    rd(44, 0);
    rd(43, 0);
    x = $urandom & 32'h000f_ffff;
    wr(0, x);
    rd(0, x);
    wrb(0, 32'h000f_ffff, 4'h1);
    rd(0, {x[31:8], 8'hff});
    wr(50, 32'h0000_1234);
    rd(50, 0);
    chk("periph_clk_en", 32'h0000_00ff, 32'(pce));
    $display("test registers done");
    pm = 8'($urandom);
    wr(1, 32'h000f_0010);
    wr(9, 32'h000f_ffff);
    wr(17, 32'h0000_0008);
    wr(2, 32'h0000_a5c3);
    wr(10, 32'h000f_ffff);
    wr(18, 32'h0000_0009);
    wr(30, 32'h0000_0006);
    wr(38, 32'h0000_0001);
    wr(42, {16'h0, pm, 8'h0});
    ij(20'hf_0010, 16'h5a3c);
    rd(44, 0);
    ij(20'hf_0010, 16'ha5c3);
    rd(44, 1);
    ck(pm);
    wr(42, 32'h0000_0003);
    ck(8'hff);
    wr(42, 32'h0000_0001);
    ck(8'h00);
    foreach (ta[i]) if (i < 3) begin
      wr(43, 32'h4 << i);
      wt(0);
      wt(1);
    end
    wr(43, 32'h0000_0002);
    wt(0);
    $display("test breakpoint done");
    v = 16'($urandom_range(32'hfffe, 1));
    wr(30, 32'h0000_0002);
    wr(3, 32'h000f_0020);
    wr(11, 32'h000f_ffff);
    wr(19, 32'h0000_0008);
    wr(31, 32'h0000_0008);
    wr(24, {16'h0, v});
    wr(26, 32'h0000_ffff);
    wr(28, 32'h0000_0005);
    wr(32, 32'h0000_0100);
    wr(40, 32'h0000_0033);
    wr(39, 32'h0000_000b);
    ij(20'hf_0010, 0);
    rd(44, 0);
    ij(20'hf_0020, 0);
    rd(44, 6);
    rwt(4, v);
    rd(44, 6);
    rwt(5, v);
    rd(44, 0);
    wr(28, 32'h0000_0035);
    ij(20'hf_0020, 0);
    rd(44, 6);
    rwt(5, v - 16'h1);
    rd(44, 6);
    ij(20'hf_0010, 0);
    rd(44, 7);
    wr(43, 32'h0000_0002);
    wr(39, 0);
    wr(38, 32'h0000_0100);
    $display("test sequencer done");
    wr(1, 32'h000f_ffff);
    wr(17, 32'h0000_000c);
    for (int i = 0; i < 10; i++) begin
      a = 20'($urandom);
      d = 16'($urandom);
      if (i < 8) ta[i] = a;
      if (i < 8) td[i] = d;
      ij(a, d);
    end
    rd(44, 32'h0000_0040);
    foreach (ta[e]) begin
      wr(45, e);
      rd(46, {9'h0, 3'h1, ta[e]});
      rd(47, {16'h0, td[e]});
    end
    wr(45, 32'h0000_0100);
    rd(44, 0);
    wr(10, 32'h0000_00ff);
    wr(30, 32'h0000_0004);
    ij(20'hf_0000, 16'h12c3);
    ij(20'hf_0000, 16'h12c4);
    rd(44, 32'h0000_0008);
    $display("test trace done");
    give_verdict();
  end
endmodule
